// File: src/flash_status_guard.sv
// Status register protection, suspend and lock tracking, array range guard
//
// Notes on behaviour
// - Two guard bits stored at S8, S7
// - Guards 00: pin ignored, write needs latch
// - Guards 01, pin low, quad off: reject status writes
// - Guards 01, pin high: write needs latch
// - Guards 10: reject writes until power cycle
// - Power cycle turns guards 10 into 00
// - Guards 11: status writes rejected forever
// - Suspend flag at S15 set by 75h
// - Suspend flag cleared by 7Ah, power-up
// - Three lock bits S13-S11, default unlocked
// - Lock bits set once, never cleared
// - Quad enable at S9, zero keeps pins
// - Quad enable makes write-protect and hold pins ignored; quad lines never driven
// - Block decode, sector bit clear
// - Block decode, sector bit set
// - Complement bit inverts decoded range
// - Ignore erase/program overlapping protected range
// - Block bits at S4-S2, default zero
// - Complement bit at S14, default zero
// - Latch cleared after program, erase, write
`timescale 1ns/1ps
`default_nettype none
module flash_status_guard (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        factoryLoad,
	input  wire logic        csN,
	input  wire logic        sclk,
	input  wire logic        dataIn,
	output logic             doOut,
	output logic             doOe,
	input  wire logic        quadLine2In,
	output logic             quadLine2Out,
	output logic             quadLine2Oe,
	input  wire logic        quadLine3In,
	output logic             quadLine3Out,
	output logic             quadLine3Oe,
	output logic             opGo,
	output logic             opBlocked,
	output logic [2:0]       opKind,
	output logic [23:0]      opAddr,
	output logic [2:0]       secureWritable,
	output logic             quadMode
);

	typedef struct packed {
		flash_guard_pkg::fsm_t st;
		logic [1:0]  csS;
		logic [1:0]  sclkS;
		logic [1:0]  diS;
		logic [1:0]  wpS;
		logic [1:0]  hdS;
		logic        csP;
		logic        sclkP;
		logic [2:0]  bitCnt;
		logic [2:0]  byteIdx;
		logic [7:0]  shIn;
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic [7:0]  srLo;
		logic [7:0]  srHi;
		logic [7:0]  outSh;
		logic        reading;
		logic        write_enable_latch;
		logic        suspended_flag;
		logic        nvWr;
		logic [15:0] nvData;
		logic        doOut;
		logic        doOe;
		logic        quadLine2Out;
		logic        quadLine2Oe;
		logic        quadLine3Out;
		logic        quadLine3Oe;
		logic        opGo;
		logic        opBlocked;
		logic [2:0]  opKind;
		logic [23:0] opAddr;
		logic [2:0]  secureWritable;
		logic        quadMode;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	nv_store_if nvBus ();
	logic [15:0]             nvWord;
	flash_guard_pkg::range_t rng;
	logic                    csRise;
	logic                    execNow;
	logic                    writeOk;
	logic                    holdAct;

	// ==========================================================
	// Non-volatile image
	nv_status_store u_store (
		.clk         (clk),
		.factoryLoad (factoryLoad),
		.port        (nvBus.store)
	);

	assign nvBus.wrEn   = s_r.nvWr;
	assign nvBus.wrData = s_r.nvData;
	assign nvWord       = nvBus.rdData;

	// ==========================================================
	// Protected range of the array for a given status image
	function automatic flash_guard_pkg::range_t guardRange(input logic [15:0] w);
		flash_guard_pkg::range_t r;
		logic [18:0] span;
		logic        none;
		logic        all;
		logic [2:0]  bp;
		r    = '0;
		span = '0;
		all  = 1'b0;
		bp   = w[flash_guard_pkg::SB_BP0 +: 3];
		none = (bp == 3'h0);
		if (!w[flash_guard_pkg::SB_SEC]) begin
			case (bp)
				3'h1:    span = flash_guard_pkg::SPAN_64K;
				3'h2:    span = flash_guard_pkg::SPAN_128K;
				3'h3:    span = flash_guard_pkg::SPAN_256K;
				default: all = !none;
			endcase
		end else begin
			case (bp)
				3'h1:    span = flash_guard_pkg::SPAN_4K;
				3'h2:    span = flash_guard_pkg::SPAN_8K;
				3'h3:    span = flash_guard_pkg::SPAN_16K;
				3'h7:    all = 1'b1;
				default: span = none ? 19'h00000 : flash_guard_pkg::SPAN_32K;
			endcase
		end
		// Top or bottom placement
		if (all) begin
			r.hit = 1'b1;
			r.hi  = flash_guard_pkg::ARRAY_TOP;
		end else if (!none) begin
			r.hit = 1'b1;
			r.lo  = w[flash_guard_pkg::SB_TB] ? 19'h00000 : flash_guard_pkg::ARRAY_TOP - span;
			r.hi  = w[flash_guard_pkg::SB_TB] ? span : flash_guard_pkg::ARRAY_TOP;
		end
		// Complement: the remaining part of the array, one piece, or nothing when the whole array is guarded
		if (w[flash_guard_pkg::SB_CMP]) begin
			if (none) begin
				r.hit = 1'b1;
				r.lo  = '0;
				r.hi  = flash_guard_pkg::ARRAY_TOP;
			end else if (all) begin
				r.hit = 1'b0;
			end else if (w[flash_guard_pkg::SB_TB]) begin
				r.lo = r.hi + 19'h00001;
				r.hi = flash_guard_pkg::ARRAY_TOP;
			end else begin
				r.hi = r.lo - 19'h00001;
				r.lo = '0;
			end
		end
		return r;
	endfunction : guardRange

	// Status word as read back: volatile flags merged with the image
	function automatic logic [15:0] statusOf(input logic [15:0] w, input logic write_enable_latch, input logic suspended_flag);
		logic [15:0] v;
		v = w & (flash_guard_pkg::NV_RW_MASK | flash_guard_pkg::LB_MASK);
		v[flash_guard_pkg::SB_WEL] = write_enable_latch;
		v[flash_guard_pkg::SB_SUS] = suspended_flag;
		return v;
	endfunction : statusOf

	// ==========================================================
	// Shared decode terms
	assign rng     = guardRange(nvWord);
	assign csRise  = s_r.csS[1] && !s_r.csP;
	assign execNow = csRise && (s_r.bitCnt == 3'd0) && (s_r.byteIdx != 3'd0) && (s_r.st != flash_guard_pkg::ST_BOOT);
	assign holdAct = !nvWord[flash_guard_pkg::SB_QE] && !s_r.hdS[1] && !s_r.csS[1];
	// Guard check: 00 free, 01 pin gated unless quad mode, 1x locked
	assign writeOk = s_r.write_enable_latch && !nvWord[flash_guard_pkg::SB_SR_GUARD_HI]
		&& (!nvWord[flash_guard_pkg::SB_SR_GUARD_LO] || nvWord[flash_guard_pkg::SB_QE] || s_r.wpS[1]);

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [7:0]  b;
		logic [7:0]  opc;
		logic [15:0] wIn;
		logic [15:0] stat;
		logic        memOp;
		logic [2:0]  kind;
		logic [2:0]  need;
		logic [18:0] span;
		logic [18:0] first;
		logic [18:0] last;
		b     = {s_r.shIn[6:0], s_r.diS[1]};
		opc   = (s_r.byteIdx == 3'd0) ? b : s_r.opcode;
		stat  = statusOf(nvWord, s_r.write_enable_latch, s_r.suspended_flag);
		wIn   = (s_r.byteIdx >= flash_guard_pkg::NB_WRSR_FULL) ? {s_r.srHi, s_r.srLo} : {nvWord[15:8], s_r.srLo};
		memOp = 1'b0;
		kind  = flash_guard_pkg::OPK_PAGE;
		need  = flash_guard_pkg::NB_PROGRAM;
		span  = flash_guard_pkg::SPAN_PAGE;
		first = '0;
		last  = '0;
		s_nxt = s_r;
		// Pin synchronisers and edge history
		s_nxt.csS   = {s_r.csS[0], csN};
		s_nxt.sclkS = {s_r.sclkS[0], sclk};
		s_nxt.diS   = {s_r.diS[0], dataIn};
		s_nxt.wpS   = {s_r.wpS[0], quadLine2In};
		s_nxt.hdS   = {s_r.hdS[0], quadLine3In};
		s_nxt.csP   = s_r.csS[1];
		s_nxt.sclkP = s_r.sclkS[1];
		s_nxt.nvWr      = 1'b0;
		s_nxt.opGo      = 1'b0;
		s_nxt.opBlocked = 1'b0;
		s_nxt.secureWritable = ~nvWord[flash_guard_pkg::SB_LB1 +: 3];
		s_nxt.quadMode       = nvWord[flash_guard_pkg::SB_QE];
		s_nxt.quadLine2Out   = 1'b0;
		s_nxt.quadLine2Oe    = 1'b0;
		s_nxt.quadLine3Out   = 1'b0;
		s_nxt.quadLine3Oe    = 1'b0;
		// Power-up: latch and suspend already clear, lock-down guard released
		case (s_r.st)
			flash_guard_pkg::ST_BOOT: begin
				s_nxt.st = flash_guard_pkg::ST_RUN;
				if (nvWord[flash_guard_pkg::SB_SR_GUARD_HI] && !nvWord[flash_guard_pkg::SB_SR_GUARD_LO]) begin
					s_nxt.nvWr   = 1'b1;
					s_nxt.nvData = nvWord & ~(16'h0001 << flash_guard_pkg::SB_SR_GUARD_HI);
				end
			end
			flash_guard_pkg::ST_RUN: begin
				if (holdAct) begin
					s_nxt.st = flash_guard_pkg::ST_HOLD;
				end
			end
			flash_guard_pkg::ST_HOLD: begin
				if (!holdAct) begin
					s_nxt.st = flash_guard_pkg::ST_RUN;
				end
			end
			default: s_nxt.st = flash_guard_pkg::ST_BOOT;
		endcase
		// Serial shifting, only while selected and not held
		if (s_r.st == flash_guard_pkg::ST_RUN && !holdAct && !s_r.csS[1]) begin
			if (s_r.sclkS[1] && !s_r.sclkP) begin
				s_nxt.shIn = b;
				s_nxt.bitCnt = s_r.bitCnt + 3'd1;
				if (s_r.bitCnt == 3'd7) begin
					if (s_r.byteIdx != 3'd7) begin
						s_nxt.byteIdx = s_r.byteIdx + 3'd1;
					end
					case (s_r.byteIdx)
						3'd0:    s_nxt.opcode = b;
						3'd1:    s_nxt.srLo = b;
						3'd2:    s_nxt.srHi = b;
						default: s_nxt.srHi = s_r.srHi;
					endcase
					if (s_r.byteIdx >= 3'd1 && s_r.byteIdx <= 3'd3) begin
						s_nxt.addr = {s_r.addr[15:0], b};
					end
					// Status bytes repeat until deselect
					if (opc == flash_guard_pkg::OP_RDSR1 || opc == flash_guard_pkg::OP_RDSR2) begin
						s_nxt.outSh   = (opc == flash_guard_pkg::OP_RDSR1) ? stat[7:0] : stat[15:8];
						s_nxt.reading = 1'b1;
					end
				end
			end else if (!s_r.sclkS[1] && s_r.sclkP && s_r.reading) begin
				s_nxt.doOut = s_r.outSh[7];
				s_nxt.outSh = {s_r.outSh[6:0], 1'b0};
				s_nxt.doOe  = 1'b1;
			end
		end else if (holdAct) begin
			s_nxt.doOe = 1'b0;
		end
		// Deselect ends the instruction
		if (s_r.csS[1]) begin
			s_nxt.bitCnt  = '0;
			s_nxt.byteIdx = '0;
			s_nxt.reading = 1'b0;
			s_nxt.doOe    = 1'b0;
		end
		// Instruction execution on deselect at a byte boundary
		if (execNow) begin
			case (s_r.opcode)
				flash_guard_pkg::OP_WREN:   s_nxt.write_enable_latch = 1'b1;
				flash_guard_pkg::OP_WRDI:   s_nxt.write_enable_latch = 1'b0;
				flash_guard_pkg::OP_SUSP:   s_nxt.suspended_flag = 1'b1;
				flash_guard_pkg::OP_RESUME: s_nxt.suspended_flag = 1'b0;
				flash_guard_pkg::OP_WRSR: begin
					// Rejected writes leave image and latch untouched
					if (s_r.byteIdx >= flash_guard_pkg::NB_WRSR_MIN && writeOk) begin
						s_nxt.nvWr   = 1'b1;
						s_nxt.nvData = (wIn & flash_guard_pkg::NV_RW_MASK)
							| ((wIn | nvWord) & flash_guard_pkg::LB_MASK);
						s_nxt.write_enable_latch    = 1'b0;
					end
				end
				flash_guard_pkg::OP_PP, flash_guard_pkg::OP_QPP: memOp = 1'b1;
				flash_guard_pkg::OP_SE: begin
					memOp = 1'b1;
					kind  = flash_guard_pkg::OPK_SECTOR;
					need  = flash_guard_pkg::NB_ERASE;
					span  = flash_guard_pkg::SPAN_4K;
				end
				flash_guard_pkg::OP_BE32: begin
					memOp = 1'b1;
					kind  = flash_guard_pkg::OPK_BLK32;
					need  = flash_guard_pkg::NB_ERASE;
					span  = flash_guard_pkg::SPAN_32K;
				end
				flash_guard_pkg::OP_BE64: begin
					memOp = 1'b1;
					kind  = flash_guard_pkg::OPK_BLK64;
					need  = flash_guard_pkg::NB_ERASE;
					span  = flash_guard_pkg::SPAN_64K;
				end
				flash_guard_pkg::OP_CE_A, flash_guard_pkg::OP_CE_B: begin
					memOp = 1'b1;
					kind  = flash_guard_pkg::OPK_CHIP;
					need  = flash_guard_pkg::NB_CHIP;
					span  = flash_guard_pkg::ARRAY_TOP;
				end
				default: s_nxt.write_enable_latch = s_r.write_enable_latch;
			endcase
		end
		// Range check of a program or erase against the guarded range
		first = s_r.addr[18:0] & ~span;
		last  = s_r.addr[18:0] | span;
		if (memOp && s_r.byteIdx >= need && s_r.write_enable_latch) begin
			s_nxt.opKind = kind;
			s_nxt.opAddr = {s_r.addr[23:19], first};
			if (rng.hit && first <= rng.hi && last >= rng.lo) begin
				s_nxt.opBlocked = 1'b1;
			end else begin
				s_nxt.opGo = 1'b1;
				s_nxt.write_enable_latch  = 1'b0;
			end
		end
		// Power-up reset: volatile state only
		if (rst) begin
			s_nxt = '0;
			s_nxt.csS   = 2'h3;
			s_nxt.csP   = 1'b1;
			s_nxt.secureWritable = 3'h7;
		end
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	// ==========================================================
	// Outputs straight from the state register
	assign doOut          = s_r.doOut;
	assign doOe           = s_r.doOe;
	assign quadLine2Out   = s_r.quadLine2Out;
	assign quadLine2Oe    = s_r.quadLine2Oe;
	assign quadLine3Out   = s_r.quadLine3Out;
	assign quadLine3Oe    = s_r.quadLine3Oe;
	assign opGo           = s_r.opGo;
	assign opBlocked      = s_r.opBlocked;
	assign opKind         = s_r.opKind;
	assign opAddr         = s_r.opAddr;
	assign secureWritable = s_r.secureWritable;
	assign quadMode       = s_r.quadMode;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_wrsrDone;
		execNow && s_r.opcode == flash_guard_pkg::OP_WRSR && s_r.byteIdx >= flash_guard_pkg::NB_WRSR_MIN;
	endsequence

	property p_srFreeWrite;
		(s_wrsrDone and (s_r.write_enable_latch && nvWord[8:7] == 2'b00)) |=> (s_r.nvWr && !s_r.write_enable_latch) ##1 (nvWord == s_r.nvData);
	endproperty
	a_srFreeWrite: assert property (p_srFreeWrite) else $error("status write with free guards not taken");

	property p_pinLocks;
		(s_wrsrDone and (nvWord[8:7] == 2'b01 && !s_r.wpS[1] && !nvWord[9])) |=> (!s_r.nvWr && s_r.write_enable_latch == $past(s_r.write_enable_latch));
	endproperty
	a_pinLocks: assert property (p_pinLocks) else $error("status write taken while pin protected");

	property p_lockDown;
		(s_r.st != flash_guard_pkg::ST_BOOT && nvWord[8]) |-> ##1 !s_r.nvWr;
	endproperty
	a_lockDown: assert property (p_lockDown) else $error("status written while locked down");

	property p_bootRelease;
		(s_r.st == flash_guard_pkg::ST_BOOT && !factoryLoad && !$past(factoryLoad)) |-> ##2 (nvWord[8:7] != 2'b10);
	endproperty
	a_bootRelease: assert property (p_bootRelease) else $error("power-up lock-down not released");

	property p_suspendSet;
		(execNow && s_r.opcode == flash_guard_pkg::OP_SUSP) |=> s_r.suspended_flag [*2];
	endproperty
	a_suspendSet: assert property (p_suspendSet) else $error("suspend flag not set");

	property p_suspendClear;
		(execNow && s_r.opcode == flash_guard_pkg::OP_RESUME) |=> !s_r.suspended_flag;
	endproperty
	a_suspendClear: assert property (p_suspendClear) else $error("suspend flag not cleared");

	property p_lockSticky;
		disable iff (rst || factoryLoad)
		!$past(factoryLoad) |-> (($past(nvWord) & ~nvWord & flash_guard_pkg::LB_MASK) == 16'h0000);
	endproperty
	a_lockSticky: assert property (p_lockSticky) else $error("lock bit cleared");

	property p_quadNoHold;
		nvWord[9] |-> ##1 (s_r.st != flash_guard_pkg::ST_HOLD || !$past(nvWord[9]));
	endproperty
	a_quadNoHold: assert property (p_quadNoHold) else $error("hold active in quad mode");

	property p_sectorTop;
		(nvWord[6:2] == 5'b10001 && !nvWord[14]) |-> (rng.hit && rng.lo == 19'h7F000 && rng.hi == 19'h7FFFF);
	endproperty
	a_sectorTop: assert property (p_sectorTop) else $error("top sector range wrong");

	property p_cmpAll;
		(nvWord[14] && nvWord[4:2] == 3'b000) |-> (rng.hit && rng.lo == 19'h00000 && rng.hi == 19'h7FFFF);
	endproperty
	a_cmpAll: assert property (p_cmpAll) else $error("complement of none is not all");

	property p_blockedNoGo;
		opBlocked |-> (!opGo && s_r.write_enable_latch == $past(s_r.write_enable_latch));
	endproperty
	a_blockedNoGo: assert property (p_blockedNoGo) else $error("blocked operation went ahead");

endmodule : flash_status_guard
`default_nettype wire

// File: src/flash_guard_pkg.sv
// Shared constants and types for the status and write-protection block
package flash_guard_pkg;

	// ==========================================================
	// Status word bit positions
	localparam int SB_WEL  = 1;
	localparam int SB_BP0  = 2;
	localparam int SB_TB   = 5;
	localparam int SB_SEC  = 6;
	localparam int SB_SR_GUARD_LO = 7;
	localparam int SB_SR_GUARD_HI = 8;
	localparam int SB_QE   = 9;
	localparam int SB_LB1  = 11;
	localparam int SB_CMP  = 14;
	localparam int SB_SUS  = 15;

	// ==========================================================
	// Masks and reset values of the non-volatile image
	localparam logic [15:0] NV_RW_MASK = 16'h43FC;  // Complement, quad, guards, sector, top/bottom, block bits
	localparam logic [15:0] LB_MASK    = 16'h3800;  // One-time lock bits
	localparam logic [15:0] NV_FACTORY = 16'h0000;

	// ==========================================================
	// Instruction codes
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_RDSR1  = 8'h05;
	localparam logic [7:0] OP_RDSR2  = 8'h35;
	localparam logic [7:0] OP_WRSR   = 8'h01;
	localparam logic [7:0] OP_PP     = 8'h02;
	localparam logic [7:0] OP_QPP    = 8'h32;
	localparam logic [7:0] OP_SE     = 8'h20;
	localparam logic [7:0] OP_BE32   = 8'h52;
	localparam logic [7:0] OP_BE64   = 8'hD8;
	localparam logic [7:0] OP_CE_A   = 8'hC7;
	localparam logic [7:0] OP_CE_B   = 8'h60;
	localparam logic [7:0] OP_SUSP   = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;

	// ==========================================================
	// Byte counts that complete each instruction kind
	localparam logic [2:0] NB_WRSR_MIN  = 3'd2;
	localparam logic [2:0] NB_WRSR_FULL = 3'd3;
	localparam logic [2:0] NB_ERASE     = 3'd4;
	localparam logic [2:0] NB_PROGRAM   = 3'd5;
	localparam logic [2:0] NB_CHIP      = 3'd1;

	// ==========================================================
	// Array geometry, spans are size minus one
	localparam logic [18:0] ARRAY_TOP = 19'h7FFFF;
	localparam logic [18:0] SPAN_PAGE = 19'h000FF;
	localparam logic [18:0] SPAN_4K   = 19'h00FFF;
	localparam logic [18:0] SPAN_8K   = 19'h01FFF;
	localparam logic [18:0] SPAN_16K  = 19'h03FFF;
	localparam logic [18:0] SPAN_32K  = 19'h07FFF;
	localparam logic [18:0] SPAN_64K  = 19'h0FFFF;
	localparam logic [18:0] SPAN_128K = 19'h1FFFF;
	localparam logic [18:0] SPAN_256K = 19'h3FFFF;

	// ==========================================================
	// Memory operation kinds reported to the program/erase engine
	localparam logic [2:0] OPK_PAGE   = 3'h0;
	localparam logic [2:0] OPK_SECTOR = 3'h1;
	localparam logic [2:0] OPK_BLK32  = 3'h2;
	localparam logic [2:0] OPK_BLK64  = 3'h3;
	localparam logic [2:0] OPK_CHIP   = 3'h4;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {ST_BOOT = 2'b00, ST_RUN = 2'b01, ST_HOLD = 2'b11} fsm_t;

	typedef struct packed {
		logic        hit;
		logic [18:0] lo;
		logic [18:0] hi;
	} range_t;

endpackage : flash_guard_pkg

// File: src/nv_store_if.sv
// Carrier between the guard logic and its non-volatile status store
`timescale 1ns/1ps
`default_nettype none
interface nv_store_if;
	logic        wrEn;
	logic [15:0] wrData;
	logic [15:0] rdData;

	modport ctrl  (output wrEn, output wrData, input rdData);
	modport store (input wrEn, input wrData, output rdData);
endinterface : nv_store_if
`default_nettype wire

// File: src/nv_status_store.sv
// Non-volatile status image that survives the power-up reset
`timescale 1ns/1ps
`default_nettype none
module nv_status_store (
	input  wire logic   clk,
	input  wire logic   factoryLoad,
	nv_store_if.store   port
);

	typedef struct packed {
		logic [15:0] word;
	} store_t;

	store_t s_r;
	store_t s_nxt;

	// ==========================================================
	// Update: factory load wins, otherwise a write replaces the image
	always_comb begin
		s_nxt = s_r;
		if (factoryLoad) begin
			s_nxt.word = flash_guard_pkg::NV_FACTORY;
		end else if (port.wrEn) begin
			s_nxt.word = port.wrData;
		end
	end

	// Deliberately not cleared by the power-up reset
	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	assign port.rdData = s_r.word;  // Read data straight from the register

endmodule : nv_status_store
`default_nettype wire

// File: dv/spi_host_model.sv
// Serial host model that frames instructions to the status guard
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic clk,
	output logic      csN,
	output logic      sclk,
	output logic      dataIn,
	input  wire logic doOut,
	input  wire logic doOe
);
	// Idle: deselected, clock parked low
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		dataIn = 1'b0;
	end

	// Shift n bytes of tx MSB first; rx keeps the last byte seen on doOut
	task automatic frame(input int n, input logic [31:0] tx, output logic [7:0] rx);
		for (int i = 0; i < n * 8; i++) begin
			@(negedge clk);
			csN = 1'b0;
			dataIn = tx[31-i];
			repeat (3) @(negedge clk);  // Low and high 4 clocks each, 200 ns period
			rx = {rx[6:0], doOe ? doOut : ~doOut};  // Undriven line shows no stale bit
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		csN = 1'b1;
		dataIn = ~dataIn; // Released line shows no stale bit
		repeat (10) @(negedge clk);
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

// File: dv/tb_flash_status_guard.sv
// Self-checking bench for status protection and array range guard
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_guard;
	logic        clk, rst, factoryLoad, csN, sclk, dataIn, doOut, doOe, wpN, holdN;
	logic        opGo, opBlocked, quadMode, ex;
	logic [2:0]  opKind, secureWritable, k;
	logic [23:0] opAddr;
	logic [7:0]  rx, sLo, sHi;
	logic [18:0] a, sp;
	logic [31:0] seed;
	int          fails, n_compared, nGo, nBlk, g0, b0;

	flash_status_guard u_flash_status_guard (.clk(clk), .rst(rst), .factoryLoad(factoryLoad), .csN(csN),
		.sclk(sclk), .dataIn(dataIn), .doOut(doOut), .doOe(doOe), .quadLine2In(wpN), .quadLine2Out(),
		.quadLine2Oe(), .quadLine3In(holdN), .quadLine3Out(), .quadLine3Oe(), .opGo(opGo),
		.opBlocked(opBlocked), .opKind(opKind), .opAddr(opAddr), .secureWritable(secureWritable),
		.quadMode(quadMode));
	spi_host_model u_spi_host_model (.clk(clk), .csN(csN), .sclk(sclk), .dataIn(dataIn), .doOut(doOut),
		.doOe(doOe));

	// ==========================================================
	// Clock and pulse counters
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (opGo === 1'b1) nGo <= nGo + 1;
		if (opBlocked === 1'b1) nBlk <= nBlk + 1;
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Expected block of an erase of span sp at aligned address a
	function automatic logic guarded(input logic cmp, sec, tb, input logic [2:0] bp, input logic [18:0] a, sp);
		logic [18:0] lo, hi, sz;
		logic        hit;
		hit = (bp != 3'h0);
		if (!sec) sz = bp[2] ? 19'h7FFFF : (19'h10000 << (bp[1:0] - 2'h1)) - 19'h1;
		else sz = (bp == 3'h7) ? 19'h7FFFF : bp[2] ? 19'h07FFF : (19'h01000 << (bp[1:0] - 2'h1)) - 19'h1;
		lo = tb ? 19'h0 : 19'h7FFFF - sz;
		hi = tb ? sz : 19'h7FFFF;
		if (cmp) begin
			if (!hit) {hit, lo, hi} = {1'b1, 19'h0, 19'h7FFFF};
			else if (sz == 19'h7FFFF) hit = 1'b0;
			else if (tb) {lo, hi} = {sz + 19'h1, 19'h7FFFF};
			else {lo, hi} = {19'h0, lo - 19'h1};
		end
		return hit && a <= hi && a + sp >= lo;
	endfunction : guarded

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cmd(input int n, input logic [31:0] tx);
		u_spi_host_model.frame(n, tx, rx);
	endtask : cmd

	task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
		cmd(1, 32'h06000000);
		cmd(3, {8'h01, lo, hi, 8'h00});
	endtask : wrsr

	task automatic rdsr(input logic [7:0] op, input logic [7:0] exp, input string what);
		cmd(2, {op, 24'h000000});
		chk(what, {24'h0, exp}, {24'h0, rx});
	endtask : rdsr

	task automatic powerUp();
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		factoryLoad = 1'b0;
		repeat (6) @(negedge clk);
	endtask : powerUp

	task automatic tally_and_finish();
		$display("TB: compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Main sequence
	initial begin
		factoryLoad = 1'b1;
		wpN = 1'b1;
		holdN = 1'b1;
		seed = 32'hBD3C;
		powerUp();
		chk("secureWritable", 32'h7, {29'h0, secureWritable});
		rdsr(8'h05, 8'h00, "reset status");
		cmd(1, 32'h06000000);
		rdsr(8'h05, 8'h02, "latch");
		cmd(1, 32'h04000000);
		cmd(3, 32'h01040000);
		rdsr(8'h05, 8'h00, "no latch");
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			sLo = {1'b0, seed[4:0], 2'b00};
			sHi = {1'b0, seed[5], 6'h00};
			a = {seed[24:18], 12'h000};
			k = seed[26] ? 3'h3 : 3'h1;
			if (i < 2) {sLo, sHi, a, k} = {8'h44, 8'h40, i ? 19'h7E000 : 19'h7F000, 3'h1};
			sp = (k == 3'h3) ? 19'h0FFFF : 19'h00FFF;
			wrsr(sLo, sHi);
			rdsr(8'h05, sLo, "low bits");
			rdsr(8'h35, sHi, "complement");
			ex = guarded(sHi[6], sLo[6], sLo[5], sLo[4:2], a & ~sp, sp);
			{g0, b0} = {nGo, nBlk};
			cmd(1, 32'h06000000);
			cmd(4, {(k == 3'h3) ? 8'hD8 : 8'h20, 5'h00, a});
			chk("blocked", {31'h0, ex}, nBlk - b0);
			chk("accepted", {31'h0, !ex}, nGo - g0);
			chk("opAddr", {13'h0, a & ~sp}, {8'h0, opAddr});
			chk("opKind", {29'h0, k}, {29'h0, opKind});
		end
		$display("TB: range test done");
		wrsr(8'h80, 8'h00);
		rdsr(8'h05, 8'h80, "guard low");
		wpN = 1'b0;
		wrsr(8'h84, 8'h00);
		rdsr(8'h05, 8'h82, "pin low");
		wpN = 1'b1;
		cmd(3, 32'h01840000);
		rdsr(8'h05, 8'h84, "pin high");
		wrsr(8'h00, 8'h0A);
		chk("quadMode", 32'h1, {31'h0, quadMode});
		chk("secureWritable", 32'h6, {29'h0, secureWritable});
		holdN = 1'b0;
		cmd(1, 32'h06000000);
		rdsr(8'h05, 8'h02, "quad ignores hold");
		holdN = 1'b1;
		wrsr(8'h00, 8'h00);
		rdsr(8'h35, 8'h08, "locks");
		chk("quadMode", 32'h0, {31'h0, quadMode});
		holdN = 1'b0;
		cmd(1, 32'h06000000);
		holdN = 1'b1;
		rdsr(8'h05, 8'h00, "hold pauses");
		cmd(1, 32'h75000000);
		rdsr(8'h35, 8'h88, "suspend");
		cmd(1, 32'h7A000000);
		rdsr(8'h35, 8'h08, "resume");
		$display("TB: guard test done");
		cmd(1, 32'h75000000);
		wrsr(8'h00, 8'h09);
		wrsr(8'h1C, 8'h08);
		rdsr(8'h05, 8'h02, "lockdown");
		powerUp();
		rdsr(8'h35, 8'h08, "power cycle");
		wrsr(8'h80, 8'h09);
		wrsr(8'h1C, 8'h08);
		rdsr(8'h05, 8'h82, "one time");
		$display("TB: lock test done");
		tally_and_finish();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
endmodule : tb_flash_status_guard
`default_nettype wire
